// ==== rtl/irq_mask_regs.sv ====
// Interrupt mask registers and transmit timestamp captures A and B.
// Assumes status events, the timer and the register port all run on i_ref_clk.
//
// Contract
// - Main bit 8 blocks stamp A footer.
// - Main bit 7 blocks PHY footer.
// - Main bit 6 reads zero; reset-done always interrupts.
// - Main bit 5 blocks header error, chunk only.
// - Main bit 4 blocks frame-loss footer.
// - Main bit 3 blocks receive overflow footer.
// - Main bit 2 blocks transmit underflow footer.
// - Main bit 1 blocks transmit overflow footer.
// - Main bit 0 blocks protocol error pin.
// - Pin mask at 0x0D, reset 0x43FA1F1A.
// - Pin bits 24..19 block port 2 events.
// - Pin bits 17, 4 block receive-ready, generic.
// - Pin bit 3 blocks frame done, generic.
// - Pin bits 12, 11 block ECC errors.
// - Pin bit 10 blocks SPI error, generic.
// - Pin bits 8, 1 block gap, link.
// - Stamp A at 0x10/0x11, reset zero.
// - Stamp B at 0x12/0x13, reset zero.
// - Main mask at 0x0C, reset 0x1FBF.
`timescale 1ns/1ps
`include "irq_cfg.svh"

module irq_mask_regs
  import irq_pkg::*;
(
  input wire i_ref_clk,
  input wire i_nrst,
  input reg_req_t i_reg_req,
  input status_t i_status,
  input wire i_chunk_mode,
  input wire [63:0] i_time,
  input wire [1:0] i_stamp_capture,
  output logic [31:0] o_reg_rdata,
  output logic o_reg_rvalid,
  output logic o_int_n,
  output logic o_footer_extended_status_flag
);

  logic wr_main;
  logic wr_pin;
  logic [31:0] main_mask_r;
  logic [31:0] pin_mask_r;
  logic [12:0] ev_main;
  logic [24:0] ev_pin;
  logic [12:0] main_open;
  logic [24:0] pin_src;
  logic footer_any;
  logic int_any;
  logic [63:0] stamp [2];
  logic pin_written_r;
  logic main_written_r;

  assign wr_main = i_reg_req.wr && (i_reg_req.addr == `OFF_MAIN_MASK);
  assign wr_pin = i_reg_req.wr && (i_reg_req.addr == `OFF_PIN_MASK);

  // Main mask: bit 6 and bits above 12 are not stored and read as zero.
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      main_mask_r <= `RST_MAIN_MASK;
    end
    else if (wr_main)
    begin
      main_mask_r <= i_reg_req.wdata & `WM_MAIN_MASK;
    end
  end

  // Pin mask: reserved bits 31:25 keep their fixed value, bit 9 is writable.
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pin_mask_r <= `RST_PIN_MASK;
    end
    else if (wr_pin)
    begin
      pin_mask_r <= (i_reg_req.wdata & `WM_PIN_MASK) | `RO_PIN_MASK;
    end
  end

  // Events in main-mask bit order.
  always_comb
  begin
    ev_main = 13'h0000;
    ev_main[`MM_TX_PROTOCOL] = i_status.tx_protocol_err;
    ev_main[`MM_TX_OVERFLOW] = i_status.tx_overflow_err;
    ev_main[`MM_TX_UNDERFLOW] = i_status.tx_underflow_err;
    ev_main[`MM_RX_OVERFLOW] = i_status.rx_overflow_err;
    ev_main[`MM_FRAME_LOSS] = i_status.frame_loss_err;
    // Header errors exist only in the chunk protocol.
    ev_main[`MM_HEADER_ERR] = i_status.header_err && i_chunk_mode;
    ev_main[`MM_PHY_EVENT] = i_status.phy_event;
    ev_main[`MM_STAMP_A] = i_status.stamp_a_avail;
    ev_main[`MM_STAMP_B] = i_status.stamp_b_avail;
    ev_main[`MM_STAMP_C] = i_status.stamp_c_avail;
    ev_main[`MM_TX_FCS] = i_status.tx_fcs_err;
    ev_main[`MM_CTRL_PROT] = i_status.ctrl_prot_err && i_chunk_mode;
  end

  // Events in pin-mask bit order; the generic-only ones drop out in chunk mode.
  always_comb
  begin
    ev_pin = 25'h0000000;
    ev_pin[`PM_LINK_CHANGE] = i_status.link_change;
    ev_pin[`PM_TX_FRAME_DONE] = i_status.tx_frame_done && !i_chunk_mode;
    ev_pin[`PM_PORT1_RX_READY] = i_status.port1_rx_ready && !i_chunk_mode;
    ev_pin[`PM_PORT1_GAP] = i_status.port1_gap_err;
    ev_pin[`PM_SPI_ERR] = i_status.spi_err && !i_chunk_mode;
    ev_pin[`PM_RX_ECC] = i_status.rx_fifo_ecc_err;
    ev_pin[`PM_TX_ECC] = i_status.tx_fifo_ecc_err;
    ev_pin[`PM_PORT2_RX_READY] = i_status.port2_rx_ready && !i_chunk_mode;
    ev_pin[`PM_PORT2_PHY] = i_status.port2_phy_event;
    ev_pin[`PM_PORT2_STAMP_A] = i_status.port2_stamp_a;
    ev_pin[`PM_PORT2_STAMP_B] = i_status.port2_stamp_b;
    ev_pin[`PM_PORT2_STAMP_C] = i_status.port2_stamp_c;
    ev_pin[`PM_PORT2_GAP] = i_status.port2_gap_err;
    ev_pin[`PM_PORT2_TX_FCS] = i_status.port2_tx_fcs_err;
  end

  // A set mask bit keeps its event away from the footer flag or the pin.
  assign main_open = ev_main & ~main_mask_r[12:0];
  assign pin_src = ev_pin & ~pin_mask_r[24:0];

  // Reset-done has no mask and reaches both outputs.
  assign footer_any = (|(main_open & `MM_FOOTER_SEL)) || i_status.reset_done_event;
  assign int_any = (|(main_open & `MM_PIN_SEL)) || (|pin_src)
    || i_status.reset_done_event;

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_footer_extended_status_flag <= 1'b0;
    end
    else
    begin
      o_footer_extended_status_flag <= footer_any;
    end
  end

  // The pin is low while any unmasked source is present, high otherwise.
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_int_n <= 1'b1;
    end
    else
    begin
      o_int_n <= !int_any;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_stamp
      stamp_capture u_cap
      (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_capture(i_stamp_capture[g]),
        .i_time(i_time),
        .o_stamp(stamp[g])
      );
    end
  endgenerate

  // Read data is returned one cycle after the read strobe; unmapped reads give zero.
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_reg_rvalid <= 1'b0;
    end
    else
    begin
      o_reg_rvalid <= i_reg_req.rd;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_reg_rdata <= 32'h00000000;
    end
    else if (i_reg_req.rd)
    begin
      case (i_reg_req.addr)
        `OFF_MAIN_MASK: o_reg_rdata <= main_mask_r;
        `OFF_PIN_MASK: o_reg_rdata <= pin_mask_r;
        `OFF_STAMP_A_HI: o_reg_rdata <= stamp[0][63:32];
        `OFF_STAMP_A_LO: o_reg_rdata <= stamp[0][31:0];
        `OFF_STAMP_B_HI: o_reg_rdata <= stamp[1][63:32];
        `OFF_STAMP_B_LO: o_reg_rdata <= stamp[1][31:0];
        default: o_reg_rdata <= 32'h00000000;
      endcase
    end
  end

  // Helper state for the checks below: has software written a mask yet.
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pin_written_r <= 1'b0;
    end
    else if (wr_pin)
    begin
      pin_written_r <= 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      main_written_r <= 1'b0;
    end
    else if (wr_main)
    begin
      main_written_r <= 1'b1;
    end
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_nrst);

  sequence s_read(logic [7:0] a);
    i_reg_req.rd && (i_reg_req.addr == a);
  endsequence

  chk_reset_done_pin: assert property (
    i_status.reset_done_event |=> !o_int_n)
    else $error("reset-done did not pull the pin low");

  chk_main_bit6_zero: assert property (
    s_read(`OFF_MAIN_MASK) |=> o_reg_rvalid && !o_reg_rdata[6])
    else $error("main mask bit 6 read as one");

  chk_main_reset_val: assert property (
    (!main_written_r and s_read(`OFF_MAIN_MASK)) |=> o_reg_rdata == 32'h00001fbf)
    else $error("main mask lost its reset value");

  chk_pin_reset_val: assert property (
    !pin_written_r |-> pin_mask_r == 32'h43fa1f1a)
    else $error("pin mask differs from reset value before any write");

  chk_stamp_a_footer: assert property (
    i_status.stamp_a_avail && !main_mask_r[8] |=> o_footer_extended_status_flag)
    else $error("unmasked stamp A did not raise the footer flag");

  chk_phy_footer_mask: assert property (
    (ev_main == 13'h0080) && main_mask_r[7] && !i_status.reset_done_event
    |=> !o_footer_extended_status_flag)
    else $error("masked PHY event raised the footer flag");

  chk_proto_err_pin: assert property (
    i_status.tx_protocol_err && !main_mask_r[0] |=> !o_int_n)
    else $error("unmasked protocol error did not pull the pin low");

  chk_pin_release: assert property (
    !int_any ##1 !int_any |-> o_int_n ##1 o_int_n)
    else $error("pin held low with no unmasked source");

  chk_stamp_a_load: assert property (
    i_stamp_capture[0] ##1 s_read(`OFF_STAMP_A_LO)
    |=> o_reg_rdata == $past(i_time[31:0], 2) || $past(i_stamp_capture[0]))
    else $error("stamp A low half does not match captured time");

  chk_stamp_b_hold: assert property (
    !i_stamp_capture[1] |=> $stable(stamp[1]))
    else $error("stamp B changed without a capture");

  chk_stamp_a_hold: assert property (
    !i_stamp_capture[0] |=> $stable(stamp[0]))
    else $error("stamp A changed without a capture");

  chk_phy_footer_open: assert property (
    i_status.phy_event && !main_mask_r[`MM_PHY_EVENT] |=> o_footer_extended_status_flag)
    else $error("unmasked PHY event did not raise the footer flag");

  chk_header_footer: assert property (
    i_status.header_err && i_chunk_mode && !main_mask_r[`MM_HEADER_ERR]
    |=> o_footer_extended_status_flag)
    else $error("unmasked header error did not raise the footer flag");

  chk_header_generic: assert property (
    (i_status == 27'h0200000) && !i_chunk_mode |=> !o_footer_extended_status_flag)
    else $error("header error raised the footer flag in generic mode");

  chk_frame_loss_footer: assert property (
    i_status.frame_loss_err && !main_mask_r[`MM_FRAME_LOSS] |=> o_footer_extended_status_flag)
    else $error("unmasked frame loss did not raise the footer flag");

  chk_rx_overflow_footer: assert property (
    i_status.rx_overflow_err && !main_mask_r[`MM_RX_OVERFLOW] |=> o_footer_extended_status_flag)
    else $error("unmasked receive overflow did not raise the footer flag");

  chk_tx_underflow_footer: assert property (
    i_status.tx_underflow_err && !main_mask_r[`MM_TX_UNDERFLOW]
    |=> o_footer_extended_status_flag)
    else $error("unmasked transmit underflow did not raise the footer flag");

  chk_tx_overflow_footer: assert property (
    i_status.tx_overflow_err && !main_mask_r[`MM_TX_OVERFLOW] |=> o_footer_extended_status_flag)
    else $error("unmasked transmit overflow did not raise the footer flag");

  chk_main_fixed_bits: assert property (
    main_mask_r[`MM_RESET_DONE] == 1'b0 && main_mask_r[31:13] == 19'h00000)
    else $error("main mask holds a one in a fixed bit");

  chk_pin_fixed_bits: assert property (
    (pin_mask_r & ~`WM_PIN_MASK) == `RO_PIN_MASK)
    else $error("pin mask fixed bits differ from their reset value");

  chk_port2_fcs_pin: assert property (
    i_status.port2_tx_fcs_err && !pin_mask_r[`PM_PORT2_TX_FCS] |=> !o_int_n)
    else $error("unmasked port 2 FCS error did not pull the pin low");

  chk_rx_ready_pin: assert property (
    ((i_status.port1_rx_ready && !pin_mask_r[`PM_PORT1_RX_READY])
    || (i_status.port2_rx_ready && !pin_mask_r[`PM_PORT2_RX_READY])) && !i_chunk_mode
    |=> !o_int_n)
    else $error("unmasked receive-ready did not pull the pin low");

  chk_frame_done_pin: assert property (
    i_status.tx_frame_done && !pin_mask_r[`PM_TX_FRAME_DONE] && !i_chunk_mode |=> !o_int_n)
    else $error("unmasked frame done did not pull the pin low");

  chk_ecc_pin: assert property (
    (i_status.tx_fifo_ecc_err && !pin_mask_r[`PM_TX_ECC])
    || (i_status.rx_fifo_ecc_err && !pin_mask_r[`PM_RX_ECC]) |=> !o_int_n)
    else $error("unmasked ECC error did not pull the pin low");

  chk_spi_err_pin: assert property (
    i_status.spi_err && !pin_mask_r[`PM_SPI_ERR] && !i_chunk_mode |=> !o_int_n)
    else $error("unmasked SPI error did not pull the pin low");

  chk_gap_link_pin: assert property (
    (i_status.port1_gap_err && !pin_mask_r[`PM_PORT1_GAP])
    || (i_status.link_change && !pin_mask_r[`PM_LINK_CHANGE]) |=> !o_int_n)
    else $error("unmasked gap error or link change did not pull the pin low");

endmodule

// ==== rtl/stamp_capture.sv ====
// One 64-bit transmit timestamp capture register.
// Assumes the capture pulse and the timer share the block clock.
`timescale 1ns/1ps
`include "irq_cfg.svh"

module stamp_capture
(
  input wire i_ref_clk,
  input wire i_nrst,
  input wire i_capture,
  input wire [63:0] i_time,
  output logic [63:0] o_stamp
);

  // The stamp holds until the next requested frame is sent.
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_stamp <= `RST_STAMP;
    end
    else if (i_capture)
    begin
      o_stamp <= i_time;
    end
  end

endmodule

// ==== shared/irq_cfg.svh ====
// Offsets, reset values, write masks and bit positions of the mask and stamp registers.
// Included by the mask register block; holds definitions only.
`ifndef IRQ_CFG_SVH
`define IRQ_CFG_SVH

`define OFF_MAIN_MASK 8'h0c
`define OFF_PIN_MASK 8'h0d
`define OFF_STAMP_A_HI 8'h10
`define OFF_STAMP_A_LO 8'h11
`define OFF_STAMP_B_HI 8'h12
`define OFF_STAMP_B_LO 8'h13

`define RST_MAIN_MASK 32'h00001fbf
`define WM_MAIN_MASK 32'h00001fbf
`define RST_PIN_MASK 32'h43fa1f1a
`define WM_PIN_MASK 32'h01fa1f1a
`define RO_PIN_MASK 32'h42000000
`define RST_STAMP 64'h0000000000000000

// Main-mask bits that gate the footer flag, and those that gate the pin.
`define MM_FOOTER_SEL 13'h17be
`define MM_PIN_SEL 13'h0801

`define MM_TX_PROTOCOL 0
`define MM_TX_OVERFLOW 1
`define MM_TX_UNDERFLOW 2
`define MM_RX_OVERFLOW 3
`define MM_FRAME_LOSS 4
`define MM_HEADER_ERR 5
`define MM_RESET_DONE 6
`define MM_PHY_EVENT 7
`define MM_STAMP_A 8
`define MM_STAMP_B 9
`define MM_STAMP_C 10
`define MM_TX_FCS 11
`define MM_CTRL_PROT 12

`define PM_LINK_CHANGE 1
`define PM_TX_FRAME_DONE 3
`define PM_PORT1_RX_READY 4
`define PM_PORT1_GAP 8
`define PM_SPI_ERR 10
`define PM_RX_ECC 11
`define PM_TX_ECC 12
`define PM_PORT2_RX_READY 17
`define PM_PORT2_PHY 19
`define PM_PORT2_STAMP_A 20
`define PM_PORT2_STAMP_B 21
`define PM_PORT2_STAMP_C 22
`define PM_PORT2_GAP 23
`define PM_PORT2_TX_FCS 24

`endif

// ==== shared/irq_pkg.sv ====
// Types carried between the mask register block and its neighbours.
// Assumes the status register bank supplies one level per event.
package irq_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic tx_protocol_err;
    logic tx_overflow_err;
    logic tx_underflow_err;
    logic rx_overflow_err;
    logic frame_loss_err;
    logic header_err;
    logic reset_done_event;
    logic phy_event;
    logic stamp_a_avail;
    logic stamp_b_avail;
    logic stamp_c_avail;
    logic tx_fcs_err;
    logic ctrl_prot_err;
    logic link_change;
    logic tx_frame_done;
    logic port1_rx_ready;
    logic port1_gap_err;
    logic spi_err;
    logic rx_fifo_ecc_err;
    logic tx_fifo_ecc_err;
    logic port2_rx_ready;
    logic port2_phy_event;
    logic port2_stamp_a;
    logic port2_stamp_b;
    logic port2_stamp_c;
    logic port2_gap_err;
    logic port2_tx_fcs_err;
  } status_t;

endpackage

// ==== testbench/irq_host_model.sv ====
// Register port driver that stands in for the SPI host processor.
// Assumes the device answers each read with a one-cycle valid pulse.
`timescale 1ns/1ps

module irq_host_model
  import irq_pkg::*;
(
  input wire i_ref_clk,
  input wire [31:0] i_rdata,
  input wire i_rvalid,
  output reg_req_t o_req
);
  initial o_req = '0;

  // Idle address and data lines are inverted so that a stale value never looks valid.
  task automatic release_bus();
    @(negedge i_ref_clk);
    o_req.wr = 1'b0;
    o_req.rd = 1'b0;
    o_req.addr = ~o_req.addr;
    o_req.wdata = ~o_req.wdata;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(negedge i_ref_clk);
    o_req.wr = 1'b1;
    o_req.addr = a;
    o_req.wdata = d;
    release_bus();
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    int n;
    @(negedge i_ref_clk);
    o_req.rd = 1'b1;
    o_req.addr = a;
    release_bus();
    n = 0;
    while (i_rvalid !== 1'b1 && n < 4)
    begin
      @(negedge i_ref_clk);
      n++;
    end
    d = (i_rvalid === 1'b1) ? i_rdata : 32'hx;
  endtask
endmodule

// ==== testbench/irq_mask_and_tx_timestamp_regs_tb_top.sv ====
// Self-checking bench for the interrupt mask registers and stamp captures.
// Assumes the host model drives the register port; the bench drives events and stamps.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end

module irq_mask_and_tx_timestamp_regs_tb_top
  import irq_pkg::*;
;
  logic clk;
  logic nrst;
  reg_req_t req;
  status_t status;
  logic chunk_mode;
  logic [63:0] time_now;
  logic [1:0] capture;
  logic [31:0] rdata;
  logic rvalid;
  logic int_n;
  logic footer;
  logic [31:0] got;
  int n_mismatch;
  int n_tests;
  int fb[10] = '{1, 2, 3, 4, 5, 7, 8, 9, 10, 12};
  int pb[14] = '{1, 3, 4, 8, 10, 11, 12, 17, 19, 20, 21, 22, 23, 24};

  irq_mask_regs i_irq_mask_regs (.i_ref_clk(clk), .i_nrst(nrst), .i_reg_req(req),
    .i_status(status), .i_chunk_mode(chunk_mode), .i_time(time_now),
    .i_stamp_capture(capture), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .o_int_n(int_n), .o_footer_extended_status_flag(footer));
  irq_host_model i_irq_host_model (.i_ref_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid),
    .o_req(req));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic print_verdict();
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic settle();
    repeat (3) @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_irq_host_model.reg_write(a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    i_irq_host_model.reg_read(a, got);
    `CHK("rdata", e, got)
  endtask

  // Raises one event, expects it to show, then masks it and expects it to vanish.
  task automatic gate(input int sb, input logic [7:0] a, input int mb, input bit pin);
    status[sb] = 1'b1;
    settle();
    `CHK("unmasked", 1'b1, pin ? ~int_n : footer)
    wr(a, 32'h1 << mb);
    settle();
    `CHK("masked", 1'b0, pin ? ~int_n : footer)
    wr(a, 32'h0);
    status[sb] = 1'b0;
    settle();
  endtask

  task automatic test_reset_values();
    `CHK("int_n", 1'b1, int_n)
    rd_chk(8'h0c, 32'h00001fbf);
    rd_chk(8'h0d, 32'h43fa1f1a);
    rd_chk(8'h10, 32'h0);
    rd_chk(8'h11, 32'h0);
    rd_chk(8'h12, 32'h0);
    rd_chk(8'h13, 32'h0);
  endtask

  task automatic test_access();
    wr(8'h0c, 32'hffffffff);
    rd_chk(8'h0c, 32'h00001fbf);
    wr(8'h0d, 32'h0);
    rd_chk(8'h0d, 32'h42000000);
    wr(8'h0d, 32'hffffffff);
    rd_chk(8'h0d, 32'h43fa1f1a);
    wr(8'h10, 32'h5a5a5a5a);
    rd_chk(8'h10, 32'h0);
    wr(8'h13, 32'ha5a5a5a5);
    rd_chk(8'h13, 32'h0);
  endtask

  task automatic test_footer();
    chunk_mode = 1'b1;
    wr(8'h0c, 32'h0);
    foreach (fb[i]) gate(26 - fb[i], 8'h0c, fb[i], 1'b0);
  endtask

  task automatic test_pin();
    chunk_mode = 1'b0;
    wr(8'h0d, 32'h0);
    gate(26, 8'h0c, 0, 1'b1);
    foreach (pb[i]) gate(13 - i, 8'h0d, pb[i], 1'b1);
  endtask

  task automatic test_modes();
    status[21] = 1'b1;
    settle();
    `CHK("footer", 1'b0, footer)
    status[21] = 1'b0;
    chunk_mode = 1'b1;
    status[12] = 1'b1;
    settle();
    `CHK("int_n", 1'b1, int_n)
    status[12] = 1'b0;
    wr(8'h0c, 32'hffffffff);
    wr(8'h0d, 32'hffffffff);
    status[20] = 1'b1;
    settle();
    `CHK("int_n", 1'b0, int_n)
    status[20] = 1'b0;
    settle();
    `CHK("int_n", 1'b1, int_n)
  endtask

  task automatic test_stamps();
    time_now = 64'h0123456789abcdef;
    capture = 2'b01;
    @(negedge clk);
    capture = 2'b00;
    time_now = 64'hfedcba9876543210;
    rd_chk(8'h11, 32'h89abcdef);
    rd_chk(8'h10, 32'h01234567);
    capture = 2'b10;
    @(negedge clk);
    capture = 2'b00;
    time_now = 64'h0;
    rd_chk(8'h12, 32'hfedcba98);
    rd_chk(8'h13, 32'h76543210);
    rd_chk(8'h11, 32'h89abcdef);
  endtask

  initial
  begin
    nrst = 1'b0;
    status = '0;
    chunk_mode = 1'b1;
    time_now = 64'h0;
    capture = 2'b00;
    n_mismatch = 0;
    n_tests = 0;
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    test_reset_values();
    test_access();
    test_footer();
    test_pin();
    test_modes();
    test_stamps();
    print_verdict();
  end

  // The whole run needs well under 5000 cycles.
  initial
  begin
    #100000;
    n_mismatch++;
    print_verdict();
  end
endmodule
